/* File: rtl/acc_pkg.sv */
// constants for the analog comparator control block
// assumes a 32-bit ahb-lite slave with word-aligned registers
package acc_pkg;
  localparam logic [7:0] ADDR_CTRL    = 8'h08;
  localparam logic [7:0] ADDR_DIS     = 8'h14;
  localparam logic [7:0] ADDR_CONVB   = 8'h18;
  localparam logic [7:0] ADDR_CONVSEL = 8'h1c;
  localparam int B_POWER_OFF = 7;
  localparam int B_BANDGAP   = 6;
  localparam int B_RESULT    = 5;
  localparam int B_FLAG      = 4;
  localparam int B_IRQ_EN    = 3;
  localparam int B_MUX_EN    = 6;
  localparam int B_CONV_EN   = 7;
  localparam logic [1:0] EDGE_TOGGLE = 2'h0;
  localparam logic [1:0] EDGE_RSVD   = 2'h1;
  localparam logic [1:0] EDGE_FALL   = 2'h2;
  localparam logic [1:0] EDGE_RISE   = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic [1:0] NEG_DEDICATED = 2'h0;
endpackage : acc_pkg

/* File: rtl/acc_sync.sv */
// two flop synchroniser for a level
// assumes the input may change at any time relative to i_clk
`timescale 1ns/100ps
module acc_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta   <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule : acc_sync

/* File: rtl/acc_top.sv */
// analog comparator control: input select, result sync, edge flag
// assumes ahb-lite master; analog comparator core sits outside
//
// Summary of operation
// - borrow on, converter off: channel picks pin
// - otherwise negative input is dedicated pin
// - bandgap select replaces positive pin input
// - result one when positive exceeds negative
// - result is synchronised, lags one-two cycles
// - flag sets on selected synchronised edge
// - flag clears on vector or written one
// - request needs flag, enable, global enable
// - mode codes: toggle, reserved, fall, rise
// - power off bit powers comparator down
// - control bit two always reads zero
// - input disable bits turn off buffers
// - disabled pin reads zero in port
// - converter enable bit blocks mux borrow
`timescale 1ns/100ps
module acc_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_cmp_raw,
  input  wire logic        i_global_irq_en,
  input  wire logic        i_vector_taken,
  input  wire logic [1:0]  i_pin_raw,
  output logic             o_irq_req,
  output logic             o_cmp_power_off,
  output logic             o_bandgap_select,
  output logic      [2:0]  o_neg_input_sel,
  output logic      [1:0]  o_buffer_off,
  output logic      [1:0]  o_pin_read
);
  // control register fields
  logic       cmp_power_off;
  logic       bandgap_select;
  logic       cmp_event_flag;
  logic       cmp_irq_enable;
  logic [1:0] edge_mode_select;
  logic [1:0] input_disable;
  logic       mux_borrow_enable;
  logic       converter_enable;
  logic [1:0] channel_field;
  logic       cmp_result_sync;
  logic       result_prev;
  // bus data phase capture
  logic       dp_write;
  logic       dp_read;
  logic [7:0] dp_addr;

  wire addr_phase = i_hsel && i_hready && (i_htrans == acc_pkg::HTRANS_NONSEQ);

  // comparator output goes through two flops before use
  acc_sync u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_cmp_raw),
    .o_sync  (cmp_result_sync)
  );

  wire rise_seen = cmp_result_sync && !result_prev;
  wire fall_seen = !cmp_result_sync && result_prev;
  wire edge_hit =
    (edge_mode_select == acc_pkg::EDGE_TOGGLE && (rise_seen || fall_seen)) ||
    (edge_mode_select == acc_pkg::EDGE_FALL && fall_seen) ||
    (edge_mode_select == acc_pkg::EDGE_RISE && rise_seen);

  wire wr_ctrl  = dp_write && dp_addr == acc_pkg::ADDR_CTRL;
  wire wr_dis   = dp_write && dp_addr == acc_pkg::ADDR_DIS;
  wire wr_convb = dp_write && dp_addr == acc_pkg::ADDR_CONVB;
  wire wr_csel  = dp_write && dp_addr == acc_pkg::ADDR_CONVSEL;
  wire flag_clr = i_vector_taken ||
                  (wr_ctrl && i_hwdata[acc_pkg::B_FLAG]);
  // a set in the clearing cycle wins so no event is lost
  wire next_flag = edge_hit ? 1'b1 : (flag_clr ? 1'b0 : cmp_event_flag);

  wire borrow = mux_borrow_enable && !converter_enable;
  wire [2:0] next_neg_sel = borrow ? {1'b1, channel_field}
                                   : {1'b0, acc_pkg::NEG_DEDICATED};

  wire [7:0] ctrl_rd = {cmp_power_off, bandgap_select, cmp_result_sync,
                        cmp_event_flag, cmp_irq_enable, 1'b0,
                        edge_mode_select};
  wire [7:0] rd_byte =
    (dp_addr == acc_pkg::ADDR_CTRL)    ? ctrl_rd :
    (dp_addr == acc_pkg::ADDR_DIS)     ? {6'h00, input_disable} :
    (dp_addr == acc_pkg::ADDR_CONVB)   ? {1'b0, mux_borrow_enable, 6'h00} :
    (dp_addr == acc_pkg::ADDR_CONVSEL) ? {converter_enable, 5'h00,
                                          channel_field} : 8'h00;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_addr  <= 8'h00;
    end else begin
      dp_write <= addr_phase && i_hwrite;
      dp_read  <= addr_phase && !i_hwrite;
      dp_addr  <= addr_phase ? i_haddr[7:0] : dp_addr;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmp_power_off    <= 1'b0;
      bandgap_select   <= 1'b0;
      cmp_irq_enable   <= 1'b0;
      edge_mode_select <= acc_pkg::EDGE_TOGGLE;
    end else if (wr_ctrl) begin
      cmp_power_off    <= i_hwdata[acc_pkg::B_POWER_OFF];
      bandgap_select   <= i_hwdata[acc_pkg::B_BANDGAP];
      cmp_irq_enable   <= i_hwdata[acc_pkg::B_IRQ_EN];
      edge_mode_select <= i_hwdata[1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      input_disable     <= 2'h0;
      mux_borrow_enable <= 1'b0;
      converter_enable  <= 1'b0;
      channel_field     <= 2'h0;
    end else begin
      if (wr_dis) input_disable <= i_hwdata[1:0];
      if (wr_convb) mux_borrow_enable <= i_hwdata[acc_pkg::B_MUX_EN];
      if (wr_csel) begin
        converter_enable <= i_hwdata[acc_pkg::B_CONV_EN];
        channel_field    <= i_hwdata[1:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      result_prev      <= 1'b0;
      cmp_event_flag   <= 1'b0;
      o_irq_req        <= 1'b0;
      o_cmp_power_off  <= 1'b0;
      o_bandgap_select <= 1'b0;
      o_neg_input_sel  <= 3'h0;
      o_buffer_off     <= 2'h0;
      o_pin_read       <= 2'h0;
      o_hrdata         <= 32'h0;
      o_hreadyout      <= 1'b1;
      o_hresp          <= 1'b0;
    end else begin
      result_prev      <= cmp_result_sync;
      cmp_event_flag   <= next_flag;
      o_irq_req        <= next_flag && cmp_irq_enable &&
                          i_global_irq_en;
      o_cmp_power_off  <= cmp_power_off;
      o_bandgap_select <= bandgap_select;
      o_neg_input_sel  <= next_neg_sel;
      o_buffer_off     <= input_disable;
      o_pin_read       <= i_pin_raw & ~input_disable;
      if (dp_read) o_hrdata <= {24'h0, rd_byte};
      // one wait state per read, so a write landing at the address edge
      // is already visible in the returned byte
      o_hreadyout      <= !(addr_phase && !i_hwrite);
      o_hresp          <= 1'b0;
    end
  end

  property p_flag_set;
    @(posedge i_clk) disable iff (!i_rst_n)
      edge_hit |=> cmp_event_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set after edge");

  property p_rsvd;
    @(posedge i_clk) disable iff (!i_rst_n)
      (edge_mode_select == acc_pkg::EDGE_RSVD && !cmp_event_flag)
        |=> !cmp_event_flag;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved mode set flag");

  property p_clear;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_vector_taken && !edge_hit) |=> !cmp_event_flag;
  endproperty
  a_clear: assert property (p_clear)
    else $error("flag not cleared");

  property p_irq;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_irq_req |-> $past(cmp_irq_enable) && $past(i_global_irq_en);
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq without enables");

  property p_neg;
    @(posedge i_clk) disable iff (!i_rst_n)
      (mux_borrow_enable && !converter_enable)
        |=> o_neg_input_sel == {1'b1, $past(channel_field)};
  endproperty
  a_neg: assert property (p_neg)
    else $error("borrowed channel not routed");

  property p_ded;
    @(posedge i_clk) disable iff (!i_rst_n)
      (!mux_borrow_enable || converter_enable)
        |=> o_neg_input_sel == 3'h0;
  endproperty
  a_ded: assert property (p_ded)
    else $error("dedicated pin not selected");

  sequence s_raw_rise;
    !i_cmp_raw ##1 i_cmp_raw [*3];
  endsequence
  property p_sync;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_raw_rise |-> cmp_result_sync;
  endproperty
  a_sync: assert property (p_sync)
    else $error("result lag exceeds two cycles");

  property p_pin;
    @(posedge i_clk) disable iff (!i_rst_n)
      (o_pin_read & $past(input_disable)) == 2'h0;
  endproperty
  a_pin: assert property (p_pin)
    else $error("disabled pin read nonzero");

  property p_rsvd_bit;
    @(posedge i_clk) disable iff (!i_rst_n)
      (dp_read && dp_addr == acc_pkg::ADDR_CTRL) |=> !o_hrdata[2];
  endproperty
  a_rsvd_bit: assert property (p_rsvd_bit)
    else $error("reserved bit read as one");

  sequence s_ctrl_write;
    (addr_phase && i_hwrite && i_haddr[7:0] == acc_pkg::ADDR_CTRL) ##1 1'b1;
  endsequence
  property p_power_bg;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_ctrl_write |=> ##1
        o_cmp_power_off == $past(i_hwdata[acc_pkg::B_POWER_OFF], 2) &&
        o_bandgap_select == $past(i_hwdata[acc_pkg::B_BANDGAP], 2);
  endproperty
  a_power_bg: assert property (p_power_bg)
    else $error("power or bandgap output not from written bits");

  sequence s_dis_write;
    (addr_phase && i_hwrite && i_haddr[7:0] == acc_pkg::ADDR_DIS) ##1 1'b1;
  endsequence
  property p_buf_off;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_dis_write |=> ##1 o_buffer_off == $past(i_hwdata[1:0], 2);
  endproperty
  a_buf_off: assert property (p_buf_off)
    else $error("buffer disable not taken from written bits");

  property p_irq_off;
    @(posedge i_clk) disable iff (!i_rst_n)
      (!cmp_irq_enable || !i_global_irq_en) |=> !o_irq_req;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("irq request while disabled");

  property p_irq_on;
    @(posedge i_clk) disable iff (!i_rst_n)
      (cmp_event_flag && !flag_clr && cmp_irq_enable && i_global_irq_en)
        |=> o_irq_req;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("irq request missing");

  property p_write_zero;
    @(posedge i_clk) disable iff (!i_rst_n)
      (cmp_event_flag && wr_ctrl && !i_hwdata[acc_pkg::B_FLAG] &&
       !i_vector_taken) |=> cmp_event_flag;
  endproperty
  a_write_zero: assert property (p_write_zero)
    else $error("flag lost on write of zero");

  property p_wrong_edge;
    @(posedge i_clk) disable iff (!i_rst_n)
      (!cmp_event_flag &&
       ((edge_mode_select == acc_pkg::EDGE_FALL && rise_seen) ||
        (edge_mode_select == acc_pkg::EDGE_RISE && fall_seen)))
        |=> !cmp_event_flag;
  endproperty
  a_wrong_edge: assert property (p_wrong_edge)
    else $error("flag set on edge of the other direction");

  sequence s_raw_fall;
    i_cmp_raw ##1 !i_cmp_raw [*3];
  endsequence
  property p_sync_fall;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_raw_fall |-> !cmp_result_sync;
  endproperty
  a_sync_fall: assert property (p_sync_fall)
    else $error("falling result lag exceeds two cycles");

  property p_result_rd;
    @(posedge i_clk) disable iff (!i_rst_n)
      (dp_read && dp_addr == acc_pkg::ADDR_CTRL)
        |=> o_hrdata[acc_pkg::B_RESULT] == $past(cmp_result_sync);
  endproperty
  a_result_rd: assert property (p_result_rd)
    else $error("result bit not read back");
endmodule : acc_top

/* File: test/acc_analog.sv */
// far side model: analog voltages on the comparator and port pins
// assumes 8-bit voltage codes and a fixed bandgap level
`timescale 1ns/100ps
module acc_analog #(
  parameter logic [7:0] BG = 8'h80
) (
  input  wire logic [7:0]  i_vpos,
  input  wire logic [7:0]  i_vneg,
  input  wire logic [31:0] i_vconv,
  input  wire logic        i_bg,
  input  wire logic        i_off,
  input  wire logic [2:0]  i_sel,
  output logic             o_cmp,
  output logic      [1:0]  o_pin
);
  logic [7:0] pos;
  logic [7:0] neg;
  assign pos = i_bg ? BG : i_vpos;
  assign neg = i_sel[2] ? i_vconv[8*i_sel[1:0] +: 8] : i_vneg;
  // a powered-down core holds its decision low
  assign o_cmp = !i_off && (pos > neg);
  assign o_pin = {i_vneg[7], i_vpos[7]};
endmodule : acc_analog

/* File: test/tb.sv */
// self-checking bench for the comparator control block
// assumes an ahb slave that may stall reads, analog model on far side
`timescale 1ns/100ps
module tb;
  logic        i_clk = 0, i_rst_n = 0, i_hsel = 0, i_hwrite = 0;
  logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, rd, vconv = 0;
  logic [1:0]  i_htrans = 0, o_buffer_off, o_pin_read, i_pin_raw;
  logic [2:0]  i_hsize = 0, o_neg_input_sel;
  logic        o_hreadyout, o_hresp, i_cmp_raw, i_vector_taken = 0;
  logic        i_global_irq_en = 0, o_irq_req, o_cmp_power_off;
  logic        o_bandgap_select;
  logic [7:0]  vpos = 8'h32, vneg = 8'h64;
  int          fails = 0, tests_run = 0;
  always #50 i_clk = ~i_clk;
  acc_top acc_top_i (.i_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans,
    .i_hwrite, .i_hsize, .i_hwdata, .i_hready(o_hreadyout), .o_hrdata,
    .o_hreadyout, .o_hresp, .i_cmp_raw, .i_global_irq_en,
    .i_vector_taken, .i_pin_raw, .o_irq_req, .o_cmp_power_off,
    .o_bandgap_select, .o_neg_input_sel, .o_buffer_off, .o_pin_read);
  acc_analog acc_analog_i (.i_vpos(vpos), .i_vneg(vneg), .i_vconv(vconv),
    .i_bg(o_bandgap_select), .i_off(o_cmp_power_off),
    .i_sel(o_neg_input_sel), .o_cmp(i_cmp_raw), .o_pin(i_pin_raw));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic hwait;
    int n;
    n = 0;
    @(posedge i_clk);
    while (o_hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fails++;
        print_verdict();
      end
      @(posedge i_clk);
    end
  endtask : hwait
  // read data is taken at the edge that closes the data phase
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    i_hsel <= 1'b1;
    i_haddr <= {24'h0, a};
    i_hwrite <= wr;
    i_htrans <= acc_pkg::HTRANS_NONSEQ;
    i_hsize <= acc_pkg::HSIZE_WORD;
    hwait();
    i_htrans <= 2'h0;
    i_hsel <= 1'b0;
    i_hwdata <= d;
    hwait();
    rd = o_hrdata;
  endtask : bus
  function automatic logic [2:0] exp_sel(logic b, logic en, logic [1:0] c);
    return (b && !en) ? {1'b1, c} : 3'h0;
  endfunction : exp_sel
  function automatic logic exp_flag(logic [1:0] m, logic rise);
    return m == acc_pkg::EDGE_TOGGLE ||
           m == (rise ? acc_pkg::EDGE_RISE : acc_pkg::EDGE_FALL);
  endfunction : exp_flag
  initial begin
    logic [7:0] r;
    void'($urandom(32'h34c8));
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    bus(0, acc_pkg::ADDR_CTRL, 0);
    chk(rd, 32'h0);
    bus(0, acc_pkg::ADDR_DIS, 0);
    chk(rd, 32'h0);
    bus(0, 8'h40, 0);
    chk(rd, 32'h0);
    $display("reset test done");
    vconv <= $urandom;
    for (int i = 0; i < 16; i++) begin
      bus(1, acc_pkg::ADDR_CONVB, {25'h0, i[0], 6'h0});
      bus(1, acc_pkg::ADDR_CONVSEL, {24'h0, i[1], 5'h0, i[3:2]});
      repeat (2) @(posedge i_clk);
      chk(o_neg_input_sel, exp_sel(i[0], i[1], i[3:2]));
    end
    $display("mux test done");
    // reserved mode keeps the flag quiet while power and bandgap move
    for (int i = 0; i < 4; i++) begin
      bus(1, acc_pkg::ADDR_CTRL, {24'h0, i[1:0], 6'h11});
      repeat (2) @(posedge i_clk);
      chk({o_cmp_power_off, o_bandgap_select}, i[1:0]);
      repeat (2) @(posedge i_clk);
      bus(0, acc_pkg::ADDR_CTRL, 0);
      chk(rd, {24'h0, i[1:0], i == 1, 5'h01});
    end
    $display("bandgap test done");
    for (int m = 0; m < 4; m++) begin
      for (int e = 1; e >= 0; e--) begin
        bus(1, acc_pkg::ADDR_CTRL, {26'h0, 4'h4, m[1:0]});
        vpos <= e[0] ? 8'h96 : 8'h32;
        repeat (5) @(posedge i_clk);
        bus(0, acc_pkg::ADDR_CTRL, 0);
        chk(rd, {26'h0, e[0], exp_flag(m[1:0], e[0]), 2'h0, m[1:0]});
      end
    end
    $display("edge test done");
    bus(1, acc_pkg::ADDR_CTRL, 32'h1b);
    i_global_irq_en <= 1'b1;
    vpos <= 8'h96;
    repeat (5) @(posedge i_clk);
    chk(o_irq_req, 1'b1);
    i_vector_taken <= 1'b1;
    @(posedge i_clk);
    i_vector_taken <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk(o_irq_req, 1'b0);
    i_global_irq_en <= 1'b0;
    vpos <= 8'h32;
    repeat (5) @(posedge i_clk);
    vpos <= 8'h96;
    repeat (5) @(posedge i_clk);
    chk(o_irq_req, 1'b0);
    bus(0, acc_pkg::ADDR_CTRL, 0);
    chk(rd, 32'h3b);
    bus(1, acc_pkg::ADDR_CTRL, 32'h03);
    bus(0, acc_pkg::ADDR_CTRL, 0);
    chk(rd, 32'h33);
    $display("irq test done");
    repeat (8) begin
      r = 8'($urandom);
      bus(1, acc_pkg::ADDR_DIS, {30'h0, r[1:0]});
      vpos <= {r[2], 7'h1};
      vneg <= {r[3], 7'h2};
      repeat (3) @(posedge i_clk);
      chk({o_buffer_off, o_pin_read}, {r[1:0], ~r[1:0] & r[3:2]});
      bus(0, acc_pkg::ADDR_DIS, 0);
      chk(rd, {30'h0, r[1:0]});
    end
    $display("disable test done");
    print_verdict();
  end
endmodule : tb
